// ### core/nfr_pkg.sv
// nfr_pkg: register map, field positions, timing constants and carriers
// of the contactless frame configuration block.
// assumes one 250 MHz clock and a 32-bit APB register port.
package nfr_pkg;
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned EGT_LIMIT_NS = 60000; // longest gap between characters
   localparam int unsigned EGT_LIMIT_CYC_DEF = EGT_LIMIT_NS / CLK_PERIOD_NS;
   localparam logic [3:0] CARRIER_UNIT_LAST = 4'hF; // 16 carrier ticks per unit
   localparam logic [1:0] DISTURB_BYTES = 2'h3;
   localparam logic [3:0] BYTE_BITS_LAST = 4'h7;
   // register indices, byte address is index times four
   localparam int unsigned IDX_GUARD_CTRL = 'h31;
   localparam int unsigned IDX_GUARD_LOW = 'h32;
   localparam int unsigned IDX_FRAME_CFG = 'h33;
   localparam int unsigned IDX_DETECT = 'h34;
   localparam int unsigned IDX_RX_CTRL = 'h35;
   localparam logic [11:0] ADDR_GUARD_CTRL = 12'(IDX_GUARD_CTRL * 4);
   localparam logic [11:0] ADDR_GUARD_LOW = 12'(IDX_GUARD_LOW * 4);
   localparam logic [11:0] ADDR_FRAME_CFG = 12'(IDX_FRAME_CFG * 4);
   localparam logic [11:0] ADDR_DETECT = 12'(IDX_DETECT * 4);
   localparam logic [11:0] ADDR_RX_CTRL = 12'(IDX_RX_CTRL * 4);
   // reset values
   localparam logic [7:0] RST_GUARD_CTRL = 8'hC0;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] FRAME_CFG_WMASK = 8'hCF;
   // guard control fields
   localparam int unsigned F_GUARD_ORIGIN = 7;
   localparam int unsigned F_GUARD_UNIT = 6;
   localparam int unsigned F_GUARD_HI_MSB = 5;
   localparam int unsigned F_GUARD_HI_LSB = 3;
   // frame config fields
   localparam int unsigned F_SEND_PAR = 7;
   localparam int unsigned F_RECV_PAR = 6;
   localparam int unsigned F_TAIL_MSB = 3;
   localparam int unsigned F_TAIL_LSB = 2;
   localparam int unsigned F_LEAD_MSB = 1;
   localparam int unsigned F_LEAD_LSB = 0;
   // receive control fields
   localparam int unsigned F_PARTIAL = 7;
   localparam int unsigned F_MULTI = 6;
   localparam int unsigned F_END_TYPE = 5;
   localparam int unsigned F_GAP_CHECK = 4;
   localparam int unsigned F_DISTURB = 3;
   localparam int unsigned F_BAUD_MSB = 2;
   localparam int unsigned F_BAUD_LSB = 0;
   // detect status fields
   localparam int unsigned F_SOF_EN = 5;
   localparam int unsigned F_SOF_SEEN = 4;
   localparam int unsigned F_CARRIER_SUB_IRQ_ENABLE = 2;
   localparam int unsigned F_SUBC_SEEN = 1;
   localparam int unsigned F_SUBC_LIVE = 0;

   typedef struct packed {
      logic sof;          // start-of-frame seen, pulse
      logic subc_live;    // subcarrier present, level
      logic byte_vld;     // full character received, pulse
      logic [7:0] data;
      logic par;          // received parity bit
      logic err;          // decode error or collision, pulse
      logic frame_end;    // end of received stream, pulse
      logic partial_vld;  // incomplete last byte pending at frame_end
      logic [7:0] partial;
   } nfr_rx_in_s;

   typedef struct packed {
      logic wr;
      logic [7:0] data;
   } nfr_fifo_wr_s;

   typedef struct packed {
      logic bit_vld;      // one data or parity bit, pulse
      logic bit_val;
      logic sym_vld;      // one framing symbol, pulse
      logic [1:0] sym;    // symbol number 0..2
   } nfr_tx_out_s;
endpackage

// ### core/nfr_frame_core.sv
// nfr_frame_core: register file and frame level logic of a contactless
// reader: transmit guard time, parity, lead/tail symbols, receive framing.
// assumes all strobes and tick inputs are synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module nfr_frame_core #(
   parameter int unsigned EGT_LIMIT_CYC = nfr_pkg::EGT_LIMIT_CYC_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic carrier_tick,
   input wire logic half_bit_tick,
   input wire logic bit_tick,
   input wire logic tx_byte_vld,
   input wire logic [7:0] tx_byte,
   input wire logic tx_byte_last,
   output logic tx_byte_rdy,
   output nfr_pkg::nfr_tx_out_s tx_out,
   output logic tx_busy,
   output logic tx_guard_done,
   input wire logic rx_start,
   input wire logic crc_enable,
   input wire logic rx_type_b,
   input wire logic [1:0] frame_end_symbol_config,
   input wire logic [7:0] rx_error_copy,
   input wire nfr_pkg::nfr_rx_in_s rx_in,
   output nfr_pkg::nfr_fifo_wr_s fifo_out,
   output logic fifo_flush,
   output logic rx_active,
   output logic rx_irq,
   output logic frame_begin_irq,
   output logic protocol_error,
   output logic parity_error,
   output logic eof_check_enable,
   output logic eof_type_b,
   output logic [5:0] rx_baud_sel
);
   import nfr_pkg::*;

   // symbol field value 1..3 maps to symbol number 0..2
   function automatic logic [1:0] sym_number(input logic [1:0] sel);
      sym_number = sel - 2'h1;
   endfunction

   // one-hot baud select, reserved codes give all zero
   function automatic logic [5:0] baud_decode(input logic [2:0] code);
      baud_decode = 6'h00;
      if (code >= 3'h2) begin
         baud_decode = 6'(7'h01 << (code - 3'h2));
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register file and APB slave
   logic [7:0] guard_low, guard_ctrl, frame_cfg, rx_ctrl;
   logic sof_en, carrier_sub_irq_enable, sof_seen, subc_seen, subc_live_q, subc_prev;
   logic [7:0] next_guard_low, next_guard_ctrl, next_frame_cfg, next_rx_ctrl;
   logic next_sof_en, next_carrier_sub_irq_enable, next_sof_seen, next_subc_seen;
   logic next_pready, next_pslverr;
   logic [31:0] next_prdata;
   logic wr_en, wr_detect, subc_rise, next_fb_irq;
   logic [7:0] detect_rd;

   // no wait state: pready rises in the first access cycle
   always_comb begin
      wr_en = psel & penable & pready & pwrite;
      wr_detect = wr_en & (paddr == ADDR_DETECT);
      subc_rise = subc_live_q & ~subc_prev;
      detect_rd = RST_ZERO;
      detect_rd[F_SOF_EN] = sof_en;
      detect_rd[F_SOF_SEEN] = sof_seen;
      detect_rd[F_CARRIER_SUB_IRQ_ENABLE] = carrier_sub_irq_enable;
      detect_rd[F_SUBC_SEEN] = subc_seen;
      detect_rd[F_SUBC_LIVE] = subc_live_q;
      next_pready = psel & ~penable;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      unique case (paddr)
         ADDR_GUARD_CTRL: next_prdata[7:0] = guard_ctrl;
         ADDR_GUARD_LOW: next_prdata[7:0] = guard_low;
         ADDR_FRAME_CFG: next_prdata[7:0] = frame_cfg;
         ADDR_DETECT: next_prdata[7:0] = detect_rd;
         ADDR_RX_CTRL: next_prdata[7:0] = rx_ctrl;
         default: next_pslverr = psel & ~penable;
      endcase
      next_guard_low = guard_low;
      next_guard_ctrl = guard_ctrl;
      next_frame_cfg = frame_cfg;
      next_rx_ctrl = rx_ctrl;
      next_sof_en = sof_en;
      next_carrier_sub_irq_enable = carrier_sub_irq_enable;
      if (wr_en && paddr == ADDR_GUARD_LOW) next_guard_low = pwdata[7:0];
      if (wr_en && paddr == ADDR_GUARD_CTRL) next_guard_ctrl = pwdata[7:0];
      if (wr_en && paddr == ADDR_FRAME_CFG) next_frame_cfg = pwdata[7:0] & FRAME_CFG_WMASK;
      if (wr_en && paddr == ADDR_RX_CTRL) next_rx_ctrl = pwdata[7:0];
      if (wr_detect) begin
         next_sof_en = pwdata[F_SOF_EN];
         next_carrier_sub_irq_enable = pwdata[F_CARRIER_SUB_IRQ_ENABLE];
      end
      // hardware set wins over a software clear in the same cycle
      next_sof_seen = rx_in.sof | (sof_seen & ~(wr_detect & ~pwdata[F_SOF_SEEN]) & ~rx_start);
      next_subc_seen = subc_rise | (subc_seen & ~(wr_detect & ~pwdata[F_SUBC_SEEN]) & ~rx_start);
      next_fb_irq = (sof_en & rx_in.sof) | (carrier_sub_irq_enable & subc_rise);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         guard_low <= RST_ZERO;
         guard_ctrl <= RST_GUARD_CTRL;
         frame_cfg <= RST_ZERO;
         rx_ctrl <= RST_ZERO;
         sof_en <= 1'b0;
         carrier_sub_irq_enable <= 1'b0;
         sof_seen <= 1'b0;
         subc_seen <= 1'b0;
         subc_live_q <= 1'b0;
         subc_prev <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         frame_begin_irq <= 1'b0;
      end else begin
         guard_low <= next_guard_low;
         guard_ctrl <= next_guard_ctrl;
         frame_cfg <= next_frame_cfg;
         rx_ctrl <= next_rx_ctrl;
         sof_en <= next_sof_en;
         carrier_sub_irq_enable <= next_carrier_sub_irq_enable;
         sof_seen <= next_sof_seen;
         subc_seen <= next_subc_seen;
         subc_live_q <= rx_in.subc_live;
         subc_prev <= subc_live_q;
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
         frame_begin_irq <= next_fb_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit guard timer
   logic [10:0] guard_cnt, next_guard_cnt, guard_target;
   logic [3:0] sub_cnt, next_sub_cnt;
   logic guard_run, next_guard_run, next_guard_done, unit_tick;
   logic tx_end_evt, rx_end_evt;

   always_comb begin
      guard_target = {guard_ctrl[F_GUARD_HI_MSB:F_GUARD_HI_LSB], guard_low};
      // either 16 carrier ticks or one half-bit tick per unit
      unit_tick = guard_ctrl[F_GUARD_UNIT] ? half_bit_tick
                  : (carrier_tick & (sub_cnt == CARRIER_UNIT_LAST));
      next_sub_cnt = sub_cnt;
      next_guard_cnt = guard_cnt;
      next_guard_run = guard_run;
      next_guard_done = tx_guard_done;
      if (guard_ctrl[F_GUARD_ORIGIN] ? rx_end_evt : tx_end_evt) begin
         next_sub_cnt = 4'h0;
         next_guard_cnt = 11'h000;
         next_guard_run = (guard_target != 11'h000);
         next_guard_done = (guard_target == 11'h000);
      end else if (guard_run) begin
         if (!guard_ctrl[F_GUARD_UNIT] && carrier_tick) next_sub_cnt = sub_cnt + 4'h1;
         if (unit_tick) begin
            next_guard_cnt = guard_cnt + 11'h001;
            if (next_guard_cnt == guard_target) begin
               next_guard_run = 1'b0;
               next_guard_done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_cnt <= 4'h0;
         guard_cnt <= 11'h000;
         guard_run <= 1'b0;
         tx_guard_done <= 1'b1;
      end else begin
         sub_cnt <= next_sub_cnt;
         guard_cnt <= next_guard_cnt;
         guard_run <= next_guard_run;
         tx_guard_done <= next_guard_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit framer: lead symbol, data bits lsb first, parity, tail symbol
   typedef enum logic [5:0] {
      TX_IDLE = 6'b000001,
      TX_LEAD = 6'b000010,
      TX_DATA = 6'b000100,
      TX_PAR = 6'b001000,
      TX_FETCH = 6'b010000,
      TX_TAIL = 6'b100000
   } nfr_tx_state_e;
   nfr_tx_state_e tx_state, next_tx_state;
   logic [7:0] tx_shift, next_tx_shift;
   logic [3:0] tx_bit_idx, next_tx_bit_idx;
   logic tx_last_q, next_tx_last, next_tx_rdy;
   nfr_tx_out_s next_tx_out;
   logic [1:0] lead_sel, tail_sel;

   always_comb begin
      lead_sel = frame_cfg[F_LEAD_MSB:F_LEAD_LSB];
      tail_sel = frame_cfg[F_TAIL_MSB:F_TAIL_LSB];
      next_tx_state = tx_state;
      next_tx_shift = tx_shift;
      next_tx_bit_idx = tx_bit_idx;
      next_tx_last = tx_last_q;
      next_tx_rdy = 1'b0;
      next_tx_out = '0;
      tx_end_evt = 1'b0;
      unique case (tx_state)
         TX_IDLE: begin
            // no frame may start before the guard interval has run out
            if (tx_byte_vld && tx_guard_done && !tx_byte_rdy) begin
               next_tx_shift = tx_byte;
               next_tx_last = tx_byte_last;
               next_tx_rdy = 1'b1;
               next_tx_bit_idx = 4'h0;
               next_tx_state = (lead_sel != 2'h0) ? TX_LEAD : TX_DATA;
            end
         end
         TX_LEAD: if (bit_tick) begin
            next_tx_out.sym_vld = 1'b1;
            next_tx_out.sym = sym_number(lead_sel);
            next_tx_state = TX_DATA;
         end
         TX_DATA: if (bit_tick) begin
            next_tx_out.bit_vld = 1'b1;
            next_tx_out.bit_val = tx_shift[tx_bit_idx[2:0]];
            next_tx_bit_idx = tx_bit_idx + 4'h1;
            if (tx_bit_idx == BYTE_BITS_LAST) begin
               if (frame_cfg[F_SEND_PAR]) next_tx_state = TX_PAR;
               else next_tx_state = tx_last_q ? TX_TAIL : TX_FETCH;
            end
         end
         TX_PAR: if (bit_tick) begin
            next_tx_out.bit_vld = 1'b1;
            next_tx_out.bit_val = ~^tx_shift; // odd parity
            next_tx_state = tx_last_q ? TX_TAIL : TX_FETCH;
         end
         TX_FETCH: if (tx_byte_vld && !tx_byte_rdy) begin
            next_tx_shift = tx_byte;
            next_tx_last = tx_byte_last;
            next_tx_rdy = 1'b1;
            next_tx_bit_idx = 4'h0;
            next_tx_state = TX_DATA;
         end
         TX_TAIL: if (bit_tick || tail_sel == 2'h0) begin
            next_tx_out.sym_vld = (tail_sel != 2'h0);
            next_tx_out.sym = sym_number(tail_sel);
            tx_end_evt = 1'b1;
            next_tx_state = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state <= TX_IDLE;
         tx_shift <= 8'h00;
         tx_bit_idx <= 4'h0;
         tx_last_q <= 1'b0;
         tx_byte_rdy <= 1'b0;
         tx_out <= '0;
         tx_busy <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         tx_shift <= next_tx_shift;
         tx_bit_idx <= next_tx_bit_idx;
         tx_last_q <= next_tx_last;
         tx_byte_rdy <= next_tx_rdy;
         tx_out <= next_tx_out;
         tx_busy <= (next_tx_state != TX_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive framing, parity strip, disturbance handling, gap check
   logic [1:0] byte_cnt, next_byte_cnt;
   logic sof_got, next_sof_got, next_rx_active, err_pend, next_err_pend;
   logic [31:0] egt_cnt, next_egt_cnt;
   logic next_flush, next_rx_irq, next_perr, next_proto, bad_char, early;
   nfr_fifo_wr_s next_fifo;

   always_comb begin
      next_byte_cnt = byte_cnt;
      next_sof_got = sof_got;
      next_rx_active = rx_active;
      next_err_pend = 1'b0;
      next_egt_cnt = egt_cnt;
      next_flush = 1'b0;
      next_rx_irq = 1'b0;
      next_perr = 1'b0;
      next_proto = 1'b0;
      next_fifo = '0;
      rx_end_evt = rx_active & rx_in.frame_end;
      bad_char = 1'b0;
      early = rx_ctrl[F_DISTURB] & (byte_cnt < DISTURB_BYTES);
      // error byte of the previous stream goes in one cycle after its end
      if (err_pend) begin
         next_fifo.wr = 1'b1;
         next_fifo.data = rx_error_copy;
      end
      if (rx_start) begin
         next_rx_active = 1'b1;
         next_byte_cnt = 2'h0;
         next_sof_got = 1'b0;
         next_egt_cnt = 32'h0;
      end else if (rx_active) begin
         if (rx_in.sof) next_sof_got = 1'b1;
         if (rx_in.byte_vld) begin
            bad_char = frame_cfg[F_RECV_PAR] & (rx_in.par != ~^rx_in.data);
            next_perr = bad_char;
            next_fifo.wr = 1'b1;
            next_fifo.data = rx_in.data; // parity bit never stored
            next_egt_cnt = 32'h0;
            if (byte_cnt != DISTURB_BYTES) next_byte_cnt = byte_cnt + 2'h1;
         end else if (rx_ctrl[F_GAP_CHECK] && rx_type_b && sof_got) begin
            // gap counter saturates at the limit so the error fires once
            if (egt_cnt < EGT_LIMIT_CYC) next_egt_cnt = egt_cnt + 32'h1;
            if (egt_cnt + 32'h1 == EGT_LIMIT_CYC) next_proto = 1'b1;
         end
         if ((rx_in.err || bad_char) && early) begin
            next_flush = 1'b1;
            next_fifo.wr = 1'b0;
            next_byte_cnt = 2'h0;
         end else if (rx_in.frame_end) begin
            if (rx_in.partial_vld && (rx_ctrl[F_PARTIAL] || !crc_enable)) begin
               next_fifo.wr = 1'b1;
               next_fifo.data = rx_in.partial;
            end
            if (early && sof_got) begin
               next_flush = 1'b1; // no irq for a short frame
               next_fifo.wr = 1'b0;
            end else begin
               next_rx_irq = 1'b1;
               next_err_pend = rx_ctrl[F_MULTI];
            end
            next_rx_active = rx_ctrl[F_MULTI];
            next_byte_cnt = 2'h0;
            next_sof_got = 1'b0;
            next_egt_cnt = 32'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_cnt <= 2'h0;
         sof_got <= 1'b0;
         rx_active <= 1'b0;
         err_pend <= 1'b0;
         egt_cnt <= 32'h0;
         fifo_flush <= 1'b0;
         rx_irq <= 1'b0;
         parity_error <= 1'b0;
         protocol_error <= 1'b0;
         fifo_out <= '0;
      end else begin
         byte_cnt <= next_byte_cnt;
         sof_got <= next_sof_got;
         rx_active <= next_rx_active;
         err_pend <= next_err_pend;
         egt_cnt <= next_egt_cnt;
         fifo_flush <= next_flush;
         rx_irq <= next_rx_irq;
         parity_error <= next_perr;
         protocol_error <= next_proto;
         fifo_out <= next_fifo;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decoded receiver settings for the bit decoder
   logic next_eof_chk;
   logic [5:0] next_baud;

   always_comb begin
      next_eof_chk = rx_ctrl[F_END_TYPE] | (|frame_end_symbol_config);
      next_baud = baud_decode(rx_ctrl[F_BAUD_MSB:F_BAUD_LSB]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eof_check_enable <= 1'b0;
         eof_type_b <= 1'b0;
         rx_baud_sel <= 6'h00;
      end else begin
         eof_check_enable <= next_eof_chk;
         eof_type_b <= rx_ctrl[F_END_TYPE];
         rx_baud_sel <= next_baud;
      end
   end
endmodule // nfr_frame_core
`default_nettype wire

// ### verification/nfr_frame_core_chk.sv
// nfr_frame_core_chk: port level assertions for the frame core.
// assumes it is bound to nfr_frame_core and that the core has one pclk domain.
`timescale 1ns/1ns
`default_nettype none
module nfr_frame_core_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic bit_tick,
   input wire logic tx_byte_rdy,
   input wire logic tx_busy,
   input wire logic tx_guard_done,
   input wire nfr_pkg::nfr_tx_out_s tx_out,
   input wire nfr_pkg::nfr_rx_in_s rx_in,
   input wire nfr_pkg::nfr_fifo_wr_s fifo_out,
   input wire logic fifo_flush,
   input wire logic rx_irq,
   input wire logic frame_begin_irq,
   input wire logic eof_check_enable,
   input wire logic eof_type_b,
   input wire logic [5:0] rx_baud_sel
);
   import nfr_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // every check samples on pclk and rests while reset is low
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_tx_gate; $rose(tx_busy) |-> $past(tx_guard_done) && tx_byte_rdy; endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("send began while guard held");
   property p_tx_slot; (tx_out.bit_vld || tx_out.sym_vld) |-> $past(bit_tick); endproperty
   a_tx_slot: assert property (p_tx_slot) else $error("send pulse without bit slot");
   property p_flush; fifo_flush |-> $past(rx_in.err || rx_in.byte_vld || rx_in.frame_end); endproperty
   a_flush: assert property (p_flush) else $error("flush without receive event");
   property p_irq; rx_irq |-> $past(rx_in.frame_end) && !fifo_flush; endproperty
   a_irq: assert property (p_irq) else $error("receive irq without clean frame end");
   // subcarrier live is seen one cycle late, so allow two cycles back
   property p_fbi; frame_begin_irq |-> $past(rx_in.sof) || $past(rx_in.subc_live) || $past(rx_in.subc_live, 2);
   endproperty
   a_fbi: assert property (p_fbi) else $error("frame begin irq without cause");
   property p_baud; $onehot0(rx_baud_sel); endproperty
   a_baud: assert property (p_baud) else $error("baud select not one-hot");
   property p_eof; eof_type_b |-> eof_check_enable; endproperty
   a_eof: assert property (p_eof) else $error("type b end without end check");
   property p_wr; fifo_out.wr && $past(rx_in.byte_vld) |-> fifo_out.data == $past(rx_in.data); endproperty
   a_wr: assert property (p_wr) else $error("fifo byte differs from received byte");
   c_irq: cover property (rx_irq);
   c_flush: cover property (fifo_flush);
   c_sym: cover property (tx_out.sym_vld);
endmodule // nfr_frame_core_chk
bind nfr_frame_core nfr_frame_core_chk u_nfr_frame_core_chk (.pclk, .presetn, .bit_tick, .tx_byte_rdy, .tx_busy,
   .tx_guard_done, .tx_out, .rx_in, .fifo_out, .fifo_flush, .rx_irq, .frame_begin_irq, .eof_check_enable,
   .eof_type_b, .rx_baud_sel);
`default_nettype wire

// ### verification/nfr_card_model.sv
// nfr_card_model: card side of the rf link, delivering decoded receive events.
// assumes the bench calls frame() right after a pclk edge.
`timescale 1ns/1ns
`default_nettype none
module nfr_card_model (
   input wire logic pclk,
   output nfr_pkg::nfr_rx_in_s rx_in
);
   import nfr_pkg::*;
   initial rx_in = '0;
   ////////////////////////////////////////////////////////////////////////////
   // sof, n bytes with odd parity one idle cycle apart, then end; byte bad gets wrong parity
   task automatic frame(input int n, input int bad);
      logic [7:0] d;
      @(posedge pclk) rx_in.sof <= 1'b1;
      rx_in.subc_live <= 1'b1;
      for (int i = 0; i < n; i++) begin
         d = 8'hA0 + 8'(i);
         @(posedge pclk) rx_in.sof <= 1'b0;
         rx_in.byte_vld <= 1'b1;
         rx_in.data <= d;
         rx_in.par <= (~^d) ^ (i == bad);
         @(posedge pclk) rx_in.byte_vld <= 1'b0;
         rx_in.data <= ~d; // released data never keeps its last value
      end
      @(posedge pclk) rx_in.frame_end <= 1'b1;
      rx_in.subc_live <= 1'b0;
      @(posedge pclk) rx_in.frame_end <= 1'b0;
   endtask
endmodule // nfr_card_model
`default_nettype wire

// ### verification/nfc_frame_rx_config_tb.sv
// nfc_frame_rx_config_tb: register, receive framing and guard time tests.
// assumes the card model drives receive events and pclk runs at 250 MHz.
`timescale 1ns/1ns
`default_nettype none
module nfc_frame_rx_config_tb;
   import nfr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, tx_byte_vld, tx_byte_rdy, tx_busy;
   logic tx_guard_done, rx_start, fifo_flush, rx_active, rx_irq, fbi, eof_check_enable, eof_type_b, perr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] tx_byte;
   logic [1:0] eof_cfg, tk;
   logic [5:0] rx_baud_sel;
   nfr_tx_out_s tx_out;
   nfr_rx_in_s rx_in;
   nfr_fifo_wr_s fifo_out;
   int fail_count, num_checks, n_irq, n_fl, n_bit, n_sym, k, n_pe;
   int lo[3] = '{2, 0, 3};
   int gc[3] = '{'h00, 'h08, 'h40};
   int cyc[3] = '{32, 4096, 6};
   logic [7:0] got[$];
   wire half_bit_tick = tk[0];
   wire bit_tick = (tk == 2'h3);
   nfr_frame_core #(.EGT_LIMIT_CYC(20)) u_nfr_frame_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .carrier_tick(1'b1), .half_bit_tick, .bit_tick, .tx_byte_vld,
      .tx_byte, .tx_byte_last(1'b1), .tx_byte_rdy, .tx_out, .tx_busy, .tx_guard_done, .rx_start,
      .crc_enable(1'b0), .rx_type_b(1'b0), .frame_end_symbol_config(eof_cfg), .rx_error_copy(8'h5A), .rx_in,
      .fifo_out, .fifo_flush, .rx_active, .rx_irq, .frame_begin_irq(fbi), .protocol_error(), .parity_error(perr),
      .eof_check_enable, .eof_type_b, .rx_baud_sel);
   nfr_card_model u_nfr_card_model (.pclk, .rx_in);
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // tick source and output monitor
   always @(posedge pclk) begin
      tk <= tk + 2'h1;
      if (fifo_out.wr) got.push_back(fifo_out.data);
      n_irq += rx_irq;
      n_fl += fifo_flush;
      n_pe += perr;
      n_bit += tx_out.bit_vld;
      n_sym += tx_out.sym_vld;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // bounded wait, a hang counts as a mismatch and ends the run
   task automatic wt(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v && n < 9000) begin
         @(posedge pclk);
         n++;
      end
      if (n == 9000) begin
         fail_count++;
         results();
      end
   endtask
   // one apb transfer, request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      wt(pready, 1'b1, k);
      rd = prdata;
      rerr = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask
   task automatic start_rx(input logic [31:0] ctrl);
      apb(1'b1, ADDR_RX_CTRL, ctrl);
      got.delete();
      {n_irq, n_fl, n_pe} = 0;
      @(posedge pclk) rx_start <= 1'b1;
      @(posedge pclk) rx_start <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, tx_byte_vld, rx_start, eof_cfg, tk} = '0;
      {fail_count, num_checks, n_irq, n_fl, n_bit, n_sym} = 0;
      tx_byte = 8'h96;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdc(ADDR_GUARD_CTRL, 32'hC0, "guard ctrl reset");
      rdc(ADDR_GUARD_LOW, 32'h00, "guard low reset");
      apb(1'b1, ADDR_FRAME_CFG, 32'hFF);
      rdc(ADDR_FRAME_CFG, 32'hCF, "frame cfg");
      rdc(12'hFFC, 32'h0, "unmapped data");
      chk(rerr, 1'b1, "unmapped error");
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, ADDR_RX_CTRL, 32'h20 | c);
         repeat (2) @(posedge pclk);
         chk(rx_baud_sel, c < 2 ? 32'h0 : 32'h1 << (c - 2), "baud select");
         chk(eof_type_b, 1'b1, "end type b");
      end
      chk(eof_check_enable, 1'b1, "end check on");
      apb(1'b1, ADDR_RX_CTRL, 32'h00);
      repeat (2) @(posedge pclk);
      chk(eof_check_enable, 1'b0, "end check off");
      eof_cfg <= 2'h2;
      $display("test receive config done");
      apb(1'b1, ADDR_FRAME_CFG, 32'h40);
      chk(eof_check_enable, 1'b1, "end symbol check");
      apb(1'b1, ADDR_DETECT, 32'h24);
      start_rx(32'h04);
      u_nfr_card_model.frame(3, 9);
      repeat (4) @(posedge pclk);
      chk(got.size(), 3, "fifo writes");
      for (int i = 0; i < 3; i++) chk(got[i], 32'hA0 + i, "fifo byte");
      rdc(ADDR_DETECT, 32'h36, "detect sticky");
      apb(1'b1, ADDR_DETECT, 32'h24);
      rdc(ADDR_DETECT, 32'h24, "detect cleared");
      start_rx(32'h44);
      u_nfr_card_model.frame(2, 9);
      repeat (4) @(posedge pclk);
      chk(got.size(), 3, "multi writes");
      chk(got[2], 32'h5A, "error byte");
      chk(rx_active, 1'b1, "still active");
      start_rx(32'h0C);
      u_nfr_card_model.frame(2, 9);
      repeat (4) @(posedge pclk);
      chk(n_fl > 0, 1'b1, "short frame flush");
      chk(n_irq, 0, "short frame irq");
      start_rx(32'h0C);
      u_nfr_card_model.frame(4, 1);
      repeat (4) @(posedge pclk);
      chk(n_fl > 0, 1'b1, "early error flush");
      chk(n_pe, 1, "parity error");
      $display("test receive done");
      apb(1'b1, ADDR_FRAME_CFG, 32'h85);
      for (int g = 0; g < 3; g++) begin
         apb(1'b1, ADDR_GUARD_LOW, 32'(lo[g]));
         apb(1'b1, ADDR_GUARD_CTRL, 32'(gc[g]));
         {n_bit, n_sym} = 0;
         @(posedge pclk) tx_byte_vld <= 1'b1;
         wt(tx_byte_rdy, 1'b1, k);
         tx_byte_vld <= 1'b0;
         wt(tx_busy, 1'b0, k);
         wt(tx_guard_done, 1'b1, k);
         chk(n_bit, 9, "sent bits");
         chk(n_sym, 2, "sent symbols");
         chk(k >= cyc[g] - 1 && k <= cyc[g] + 2, 1'b1, "guard cycles");
      end
      $display("test guard done");
      results();
   end
endmodule // nfc_frame_rx_config_tb
`default_nettype wire
